//--- hw/ao_ctrl_regs.sv
/*
 * Analog output control bank: a serial-bus target holding the gain
 * boost and common-mode control registers, and the logic they steer.
 * Assumes scl/sda are already synchronous to mclk and that the bus
 * master follows the standard two-wire protocol; sda is open drain.
 */
`timescale 1ns/1ps

module ao_ctrl_regs #(
	parameter logic [6:0] DEV_ADDR = ao_pkg::AO_DEV_ADDR_DEF,
	parameter int SAMPLE_W = ao_pkg::AO_SAMPLE_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic shared_deemph_common_pin,
	input wire logic sample_valid,
	input wire logic signed [SAMPLE_W-1:0] left_in,
	input wire logic signed [SAMPLE_W-1:0] right_in,
	output logic signed [SAMPLE_W-1:0] left_out,
	output logic signed [SAMPLE_W-1:0] right_out,
	output logic out_valid,
	output logic deemph_active,
	output logic common_mode_powerdown,
	output logic left_amplitude_boost,
	output logic right_amplitude_boost
);
	import ao_pkg::*;

	// ==========================================================
	// Bus event detection
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise = scl_in && !scl_prev_q;
	assign scl_fall = !scl_in && scl_prev_q;
	assign bus_start = scl_in && scl_prev_q && sda_prev_q && !sda_in;
	assign bus_stop = scl_in && scl_prev_q && !sda_prev_q && sda_in;

	// ==========================================================
	// Target state
	ao_state_e st_q;
	logic [3:0] cnt_q;
	logic [7:0] shreg_q;
	logic [7:0] ptr_q;
	logic [7:0] txbyte_q;
	logic rw_q;
	logic nack_q;
	ao_cfg_s cfg_q;

	logic [7:0] ptr_next;
	logic [7:0] rd_now;
	logic [7:0] rd_next;
	logic addr_hit;
	logic wr_strobe;
	logic last_bit;
	logic ack_end;

	assign ptr_next = ptr_q + 8'h01;
	assign last_bit = scl_fall && cnt_q == AO_LAST_BIT;
	assign ack_end = scl_fall && cnt_q == AO_ACK_SLOT;
	assign addr_hit = shreg_q[7:1] == DEV_ADDR;
	assign wr_strobe = last_bit && st_q == AO_WDATA;

	assign rd_now = (ptr_q == AO_OFS_GAIN_BOOST) ?
		{3'h0, cfg_q.left_boost, 3'h0, cfg_q.right_boost} :
		(ptr_q == AO_OFS_CM_CTRL) ? {6'h00, cfg_q.deemph_en, cfg_q.cm_pd} : 8'h00;
	assign rd_next = (ptr_next == AO_OFS_GAIN_BOOST) ?
		{3'h0, cfg_q.left_boost, 3'h0, cfg_q.right_boost} :
		(ptr_next == AO_OFS_CM_CTRL) ? {6'h00, cfg_q.deemph_en, cfg_q.cm_pd} : 8'h00;

	always_ff @(posedge mclk) begin
		if (reset) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else if (ce) begin
			scl_prev_q <= scl_in;
			sda_prev_q <= sda_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= AO_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= 8'h00;
			ptr_q <= 8'h00;
			txbyte_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (ce) begin
			if (bus_start) begin
				st_q <= AO_ADDR;
				// The scl fall that ends the START carries no bit
				cnt_q <= AO_CNT_ARM;
				sda_oe_n <= 1'b1;
			end else if (bus_stop) begin
				st_q <= AO_IDLE;
				sda_oe_n <= 1'b1;
			end else if (st_q != AO_IDLE) begin
				if (scl_rise && cnt_q < AO_ACK_SLOT) begin
					shreg_q <= {shreg_q[6:0], sda_in};
				end
				if (scl_rise && cnt_q == AO_ACK_SLOT) begin
					nack_q <= sda_in;
				end
				if (last_bit) begin
					cnt_q <= AO_ACK_SLOT;
					sda_oe_n <= 1'b0;
					case (st_q)
						AO_ADDR: begin
							rw_q <= shreg_q[0];
							// Foreign address: leave the bus alone
							if (!addr_hit) begin
								st_q <= AO_IDLE;
								sda_oe_n <= 1'b1;
							end
						end
						AO_PTR: ptr_q <= shreg_q;
						AO_WDATA: ptr_q <= ptr_next;
						default: sda_oe_n <= 1'b1;
					endcase
				end else if (ack_end) begin
					cnt_q <= 4'h0;
					sda_oe_n <= 1'b1;
					case (st_q)
						AO_ADDR: begin
							if (rw_q) begin
								st_q <= AO_RDATA;
								txbyte_q <= rd_now;
								sda_oe_n <= rd_now[7];
							end else begin
								st_q <= AO_PTR;
							end
						end
						AO_RDATA: begin
							if (nack_q) begin
								st_q <= AO_IDLE;
							end else begin
								ptr_q <= ptr_next;
								txbyte_q <= rd_next;
								sda_oe_n <= rd_next[7];
							end
						end
						default: st_q <= AO_WDATA;
					endcase
				end else if (scl_fall) begin
					cnt_q <= cnt_q + 4'h1;
					if (st_q == AO_RDATA) begin
						// Drive low for a zero bit, release for a one
						sda_oe_n <= txbyte_q[3'h6 - cnt_q[2:0]];
					end
				end
			end
		end
	end

	// ==========================================================
	// Configuration registers
	// volatile, reset values
	always_ff @(posedge mclk) begin
		if (reset) begin
			cfg_q <= AO_CFG_RST;
		end else if (ce && wr_strobe) begin
			if (ptr_q == AO_OFS_GAIN_BOOST) begin
				cfg_q.left_boost <= shreg_q[AO_BIT_LEFT_BOOST];
				cfg_q.right_boost <= shreg_q[AO_BIT_RIGHT_BOOST];
			end else if (ptr_q == AO_OFS_CM_CTRL) begin
				cfg_q.deemph_en <= shreg_q[AO_BIT_DEEMPH_EN];
				cfg_q.cm_pd <= shreg_q[AO_BIT_CM_PD];
			end
		end
	end

	// ==========================================================
	// Steered outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			sda_out <= 1'b0;
			out_valid <= 1'b0;
			deemph_active <= 1'b0;
			common_mode_powerdown <= AO_RST_CM_PD;
			left_amplitude_boost <= AO_RST_LEFT_BOOST;
			right_amplitude_boost <= AO_RST_RIGHT_BOOST;
		end else if (ce) begin
			sda_out <= 1'b0;
			out_valid <= sample_valid;
			deemph_active <= cfg_q.deemph_en & shared_deemph_common_pin;
			common_mode_powerdown <= cfg_q.cm_pd;
			left_amplitude_boost <= cfg_q.left_boost;
			right_amplitude_boost <= cfg_q.right_boost;
		end
	end

	ao_boost #(.W(SAMPLE_W)) u_left (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.boost_en(cfg_q.left_boost),
		.in_valid(sample_valid),
		.in_sample(left_in),
		.out_sample(left_out)
	);

	ao_boost #(.W(SAMPLE_W)) u_right (
		.mclk(mclk),
		.reset(reset),
		.ce(ce),
		.boost_en(cfg_q.right_boost),
		.in_valid(sample_valid),
		.in_sample(right_in),
		.out_sample(right_out)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_reset_vals;
		@(posedge mclk) disable iff (1'b0) reset |=> cfg_q == AO_CFG_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_cm_pd;
		ce ##1 ce |-> common_mode_powerdown == $past(cfg_q.cm_pd);
	endproperty
	a_cm_pd: assert property (p_cm_pd) else $error("powerdown output not following");

	property p_deemph;
		ce && !cfg_q.deemph_en |=> !deemph_active;
	endproperty
	a_deemph: assert property (p_deemph) else $error("pin acted while disabled");

	property p_reserved;
		st_q == AO_RDATA |-> txbyte_q[7:5] == 3'h0 && txbyte_q[3:2] == 2'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	sequence s_addr_done;
		ce && last_bit && st_q == AO_ADDR && addr_hit;
	endsequence
	property p_addr_ack;
		s_addr_done ##1 1'b1 |-> !sda_oe_n && cnt_q == AO_ACK_SLOT;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("no ack for own address");

	property p_left_write;
		ce && wr_strobe && ptr_q == AO_OFS_GAIN_BOOST ##1 ce
			|=> left_amplitude_boost == $past(shreg_q[AO_BIT_LEFT_BOOST], 2);
	endproperty
	a_left_write: assert property (p_left_write) else $error("left boost not written");

	property p_right_write;
		ce && wr_strobe && ptr_q == AO_OFS_GAIN_BOOST ##1 ce
			|=> right_amplitude_boost == $past(shreg_q[AO_BIT_RIGHT_BOOST], 2);
	endproperty
	a_right_write: assert property (p_right_write) else $error("right boost not written");

endmodule : ao_ctrl_regs

//--- hw/ao_pkg.sv
/*
 * Shared constants and types for the analog output control bank:
 * register offsets, field positions, reset values, boost scaling.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package ao_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] AO_OFS_GAIN_BOOST = 8'h07;
	localparam logic [7:0] AO_OFS_CM_CTRL = 8'h09;

	localparam int AO_BIT_LEFT_BOOST = 4;
	localparam int AO_BIT_RIGHT_BOOST = 0;
	localparam int AO_BIT_DEEMPH_EN = 1;
	localparam int AO_BIT_CM_PD = 0;

	localparam logic AO_RST_LEFT_BOOST = 1'h0;
	localparam logic AO_RST_RIGHT_BOOST = 1'h0;
	localparam logic AO_RST_DEEMPH_EN = 1'h0;
	localparam logic AO_RST_CM_PD = 1'h1;

	// ==========================================================
	// Boost scaling: 1126/1024 is about +10 % (+0.8 dB)
	localparam logic signed [11:0] AO_BOOST_MUL = 12'sh466;
	localparam int AO_BOOST_SHIFT = 10;
	localparam int AO_SAMPLE_W = 24;

	// ==========================================================
	// Serial target
	localparam logic [6:0] AO_DEV_ADDR_DEF = 7'h2A;
	localparam logic [3:0] AO_LAST_BIT = 4'h7;
	localparam logic [3:0] AO_ACK_SLOT = 4'h8;
	// Count after a START: the scl fall that closes the START wraps it to zero
	localparam logic [3:0] AO_CNT_ARM = 4'hF;

	typedef enum logic [2:0] {
		AO_IDLE,
		AO_ADDR,
		AO_PTR,
		AO_WDATA,
		AO_RDATA
	} ao_state_e;

	typedef struct packed {
		logic left_boost;
		logic right_boost;
		logic deemph_en;
		logic cm_pd;
	} ao_cfg_s;

	localparam ao_cfg_s AO_CFG_RST = '{
		left_boost: AO_RST_LEFT_BOOST,
		right_boost: AO_RST_RIGHT_BOOST,
		deemph_en: AO_RST_DEEMPH_EN,
		cm_pd: AO_RST_CM_PD
	};

endpackage : ao_pkg

//--- hw/ao_boost.sv
/*
 * One channel of the amplitude boost stage: passes samples unchanged
 * or scaled by about 1.1 with saturation, one register stage.
 * Assumes samples arrive with a one-cycle valid strobe on mclk.
 */
`timescale 1ns/1ps

module ao_boost #(
	parameter int W = ao_pkg::AO_SAMPLE_W
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ce,
	input wire logic boost_en,
	input wire logic in_valid,
	input wire logic signed [W-1:0] in_sample,
	output logic signed [W-1:0] out_sample
);
	import ao_pkg::*;

	localparam logic signed [W-1:0] SAT_MAX = {1'b0, {(W-1){1'b1}}};
	localparam logic signed [W-1:0] SAT_MIN = {1'b1, {(W-1){1'b0}}};

	logic signed [W+11:0] prod;
	logic signed [W+11:0] scaled;
	logic [12:0] hi;
	logic fits;
	logic signed [W-1:0] boosted;
	logic signed [W-1:0] out_d;

	assign prod = in_sample * AO_BOOST_MUL;
	assign scaled = prod >>> AO_BOOST_SHIFT;
	assign hi = scaled[W+11:W-1];
	// Clipping beats wrap-around: a wrapped peak is a loud click
	assign fits = (&hi) | ~(|hi);
	assign boosted = fits ? scaled[W-1:0] : (in_sample[W-1] ? SAT_MIN : SAT_MAX);
	assign out_d = boost_en ? boosted : in_sample;

	always_ff @(posedge mclk) begin
		if (reset) begin
			out_sample <= '0;
		end else if (ce && in_valid) begin
			out_sample <= out_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	property p_pass_through;
		ce && in_valid && !boost_en |=> out_sample == $past(in_sample);
	endproperty
	a_pass_through: assert property (p_pass_through) else $error("unboosted sample altered");

	property p_boost_grows;
		ce && in_valid && boost_en && in_sample > 24'sh000400 && in_sample < 24'sh700000
			|=> out_sample > $past(in_sample);
	endproperty
	a_boost_grows: assert property (p_boost_grows) else $error("boost did not raise level");

endmodule : ao_boost

//--- tb/ao_host_model.sv
/*
 * Host master model for the two-wire register bus.
 * Assumes the bench resolves sda with a pull-up.
 */
`timescale 1ns/1ps
module ao_host_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sda_rel,
	output int nack_cnt
);
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
		nack_cnt = 0;
	end
	// ====================
	// Bus phases, three mclk each
	task automatic gap();
		repeat (3) @(posedge mclk);
	endtask : gap
	task automatic bit_x(input logic d, output logic r);
		gap();
		sda_rel <= d;
		gap();
		scl <= 1'b1;
		gap();
		r = sda;
		scl <= 1'b0;
	endtask : bit_x
	task automatic start_c();
		sda_rel <= 1'b1;
		gap();
		scl <= 1'b1;
		gap();
		sda_rel <= 1'b0;
		gap();
		scl <= 1'b0;
	endtask : start_c
	task automatic stop_c();
		gap();
		sda_rel <= 1'b0;
		gap();
		scl <= 1'b1;
		gap();
		sda_rel <= 1'b1;
		gap();
	endtask : stop_c
	task automatic byte_x(input logic [7:0] d, input logic want, output logic [7:0] r);
		logic a;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
		bit_x(1'b1, a);
		if (want && a) nack_cnt++;
	endtask : byte_x
	task automatic point(input logic [7:0] ofs);
		logic [7:0] r;
		start_c();
		byte_x({ADDR, 1'b0}, 1'b1, r);
		byte_x(ofs, 1'b1, r);
	endtask : point
	task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
		logic [7:0] r;
		point(ofs);
		byte_x(v, 1'b1, r);
		stop_c();
	endtask : wr
	// Single byte read, closed by a master NACK
	task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
		logic [7:0] r;
		point(ofs);
		start_c();
		byte_x({ADDR, 1'b1}, 1'b1, r);
		byte_x(8'hFF, 1'b0, v);
		stop_c();
	endtask : rd
endmodule : ao_host_model

//--- tb/tb_ao_ctrl_regs.sv
/*
 * Self-checking bench for the analog output control bank.
 * Assumes the host model and a pulled-up sda wire.
 */
`timescale 1ns/1ps
module tb_ao_ctrl_regs;
	import ao_pkg::*;
	logic mclk, reset, ce, sv, pin, scl, rel, so, oe_n, ov, dea, cmp, lb, rb;
	logic signed [23:0] li, ri, lo, ro;
	logic [31:0] seed = 32'h1D;
	logic [7:0] rv;
	logic signed [23:0] lo_hold;
	int error_cnt = 0;
	int n_checks = 0;
	int nk;
	int cyc = 0;
	wire sda = rel & (oe_n | so);
	ao_ctrl_regs i_dut (.mclk(mclk), .reset(reset), .ce(ce), .scl_in(scl), .sda_in(sda),
		.sda_out(so), .sda_oe_n(oe_n), .shared_deemph_common_pin(pin), .sample_valid(sv),
		.left_in(li), .right_in(ri), .left_out(lo), .right_out(ro), .out_valid(ov),
		.deemph_active(dea), .common_mode_powerdown(cmp), .left_amplitude_boost(lb),
		.right_amplitude_boost(rb));
	ao_host_model i_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_rel(rel), .nack_cnt(nk));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	// ====================
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic signed [23:0] bst(input logic signed [23:0] x, input logic en);
		longint p;
		p = en ? (longint'(x) * AO_BOOST_MUL) >>> AO_BOOST_SHIFT : longint'(x);
		if (p > 64'sh7FFFFF) p = 64'sh7FFFFF;
		if (p < -64'sh800000) p = -64'sh800000;
		return p[23:0];
	endfunction : bst
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	// About 30 transfers of under 500 cycles each
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			chk("timeout", 1, 0);
			summarize();
		end
	end
	task automatic smp(input logic signed [23:0] l, r, input logic bl, br);
		@(posedge mclk);
		sv <= 1'b1;
		li <= l;
		ri <= r;
		@(posedge mclk);
		sv <= 1'b0;
		@(negedge mclk);
		chk("out_valid", ov, 1'b1);
		chk("left_out", lo, bst(l, bl));
		chk("right_out", ro, bst(r, br));
	endtask : smp
	task automatic rst_chk();
		repeat (2) @(posedge mclk);
		#1;
		chk("cm_pd_out", cmp, 1'b1);
		chk("flags", {lb, rb, dea}, 3'h0);
		i_host.rd(AO_OFS_GAIN_BOOST, rv);
		chk("gain_rd", rv, 8'h00);
		i_host.rd(AO_OFS_CM_CTRL, rv);
		chk("cm_rd", rv, 8'h01);
	endtask : rst_chk
	// ====================
	// Main sequence
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		sv = 1'b0;
		pin = 1'b0;
		li = '0;
		ri = '0;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		rst_chk();
		// Every boost pairing; the last also sets reserved bits
		for (int k = 0; k < 4; k++) begin
			i_host.wr(AO_OFS_GAIN_BOOST, {3'h0, k[1], 3'h0, k[0]} | (k == 3 ? 8'hEE : 8'h00));
			i_host.rd(AO_OFS_GAIN_BOOST, rv);
			chk("gain_rd", rv, {3'h0, k[1], 3'h0, k[0]});
			chk("boost_out", {lb, rb}, k[1:0]);
			smp(24'sh7FFFFF, 24'sh800000, k[1], k[0]);
			repeat (3) begin
				seed = lfsr(seed);
				smp(seed[23:0], seed[31:8], k[1], k[0]);
			end
		end
		// Each control setting against both pin levels
		for (int j = 0; j < 8; j++) begin
			pin <= j[2];
			i_host.wr(AO_OFS_CM_CTRL, {6'h00, j[1:0]} | (j == 0 ? 8'hFC : 8'h00));
			i_host.rd(AO_OFS_CM_CTRL, rv);
			chk("cm_rd", rv, {6'h00, j[1:0]});
			chk("deemph", dea, j[1] & j[2]);
			chk("cm_pd_out", cmp, j[0]);
		end
		i_host.wr(8'h08, 8'hFF);
		i_host.rd(8'h08, rv);
		chk("unmapped_rd", rv, 8'h00);
		i_host.rd(AO_OFS_GAIN_BOOST, rv);
		chk("gain_rd", rv, 8'h11);
		// Clock enable low must freeze the sample path
		@(posedge mclk);
		ce <= 1'b0;
		sv <= 1'b1;
		li <= 24'sh123456;
		lo_hold = lo;
		@(posedge mclk);
		@(negedge mclk);
		chk("ce_valid", ov, 1'b0);
		chk("ce_left", lo, lo_hold);
		@(posedge mclk);
		sv <= 1'b0;
		ce <= 1'b1;
		// Reset in mid-run with a non-default setup in place
		@(posedge mclk);
		reset <= 1'b1;
		repeat (3) @(posedge mclk);
		reset <= 1'b0;
		rst_chk();
		i_host.wr(AO_OFS_CM_CTRL, 8'h02);
		chk("cm_pd_out", cmp, 1'b0);
		chk("deemph", dea, 1'b1);
		chk("nacks", nk, 0);
		summarize();
	end
endmodule : tb_ao_ctrl_regs
